// >>> cpmc_top.sv
/*
 * Clock and power mode control: register port, two key sequencers, the
 * keyed control registers, wake logic and the core clock tick divider.
 * Assumes the register master keeps strobes one cycle long and never both at
 * once, and that the interrupt lines are synchronous to core_clk.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module cpmc_top (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [cpmc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cpmc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [cpmc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [3:0] external_interrupt_lines,
	output logic low_freq_source_select,
	output logic [1:0] clocking_mode_field,
	output logic [2:0] power_mode_field,
	output logic [2:0] core_divider_field,
	output logic [1:0] serial_source_clock,
	output logic core_tick,
	output logic wake_event
);
	import cpmc_pkg::*;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	logic hit_pk1;
	logic hit_pmc;
	logic hit_pk2;
	logic hit_ck1;
	logic hit_csc;
	logic hit_ck2;
	logic hit_pcc;

	// One compare per register
	assign hit_pk1 = reg_addr == ADDR_POWER_KEY_FIRST;
	assign hit_pmc = reg_addr == ADDR_POWER_MODE_CONTROL;
	assign hit_pk2 = reg_addr == ADDR_POWER_KEY_SECOND;
	assign hit_ck1 = reg_addr == ADDR_CLOCK_KEY_FIRST;
	assign hit_csc = reg_addr == ADDR_CLOCK_SYSTEM_CONTROL;
	assign hit_ck2 = reg_addr == ADDR_CLOCK_KEY_SECOND;
	assign hit_pcc = reg_addr == ADDR_PERIPHERAL_CLOCK_CONTROL;

	// ****************************************************************
	// Key sequencers
	// ****************************************************************
	cpmc_key_if clk_kif ();
	cpmc_key_if pwr_kif ();

	// Clock side sees every strobe so that any other access aborts
	assign clk_kif.access = reg_wr || reg_rd;
	assign clk_kif.key1_wr = reg_wr && hit_ck1;
	assign clk_kif.val_wr = reg_wr && hit_csc;
	assign clk_kif.key2_wr = reg_wr && hit_ck2;
	assign clk_kif.val_sel = 1'b0;
	assign clk_kif.wdata = reg_wdata[7:0];

	// Power keys guard both the mode and the peripheral clock register
	assign pwr_kif.access = reg_wr || reg_rd;
	assign pwr_kif.key1_wr = reg_wr && hit_pk1;
	assign pwr_kif.val_wr = reg_wr && (hit_pmc || hit_pcc);
	assign pwr_kif.key2_wr = reg_wr && hit_pk2;
	assign pwr_kif.val_sel = hit_pcc;
	assign pwr_kif.wdata = reg_wdata[7:0];

	cpmc_key_seq #(
		.FIRST_CODE(CLOCK_KEY_FIRST_CODE),
		.SECOND_CODE(CLOCK_KEY_SECOND_CODE)
	) u_clk_seq (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.kif(clk_kif.seq)
	);

	cpmc_key_seq #(
		.FIRST_CODE(POWER_KEY_FIRST_CODE),
		.SECOND_CODE(POWER_KEY_SECOND_CODE)
	) u_pwr_seq (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.kif(pwr_kif.seq)
	);

	// ****************************************************************
	// Clock system control
	// ****************************************************************
	logic [1:0] next_clk_mode;
	logic mode_legal;

	// Only 01 and 11 are real modes, so bit 0 set means legal
	assign next_clk_mode = clk_kif.commit_data[CLOCKING_MODE_LSB +: 2];
	assign mode_legal = (next_clk_mode == CLOCKING_MODE_PLL) || (next_clk_mode == CLOCKING_MODE_EXTERNAL);

	// Reference select and clocking mode, changed only by a commit
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			low_freq_source_select <= CLOCK_SYSTEM_RESET[LOW_FREQ_SOURCE_BIT];
			clocking_mode_field <= CLOCK_SYSTEM_RESET[CLOCKING_MODE_LSB +: 2];
		end else if (clk_kif.commit) begin
			low_freq_source_select <= clk_kif.commit_data[LOW_FREQ_SOURCE_BIT];
			// Reserved codes leave the running mode alone
			if (mode_legal) clocking_mode_field <= next_clk_mode;
		end
	end

	// ****************************************************************
	// Power mode control and wake
	// ****************************************************************
	logic [2:0] next_pmode;
	logic pmode_legal;
	logic power_commit;
	logic periph_commit;
	logic asleep;
	logic wake;

	assign next_pmode = pwr_kif.commit_data[POWER_MODE_LSB +: 3];
	assign pmode_legal = next_pmode <= 3'(CPMC_STOP);
	assign power_commit = pwr_kif.commit && !pwr_kif.commit_sel;
	assign periph_commit = pwr_kif.commit && pwr_kif.commit_sel;
	assign asleep = (power_mode_field == 3'(CPMC_SLEEP)) || (power_mode_field == 3'(CPMC_STOP));
	assign wake = asleep && (external_interrupt_lines != 4'h0);

	// Wake beats a same-cycle commit: an interrupt must never be slept through
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			power_mode_field <= POWER_MODE_RESET[POWER_MODE_LSB +: 3];
		end else if (wake) begin
			power_mode_field <= 3'(CPMC_ACTIVE);
		end else if (power_commit && pmode_legal) begin
			power_mode_field <= next_pmode;
		end
	end

	// Divider follows any power commit, including one with a reserved mode
	always_ff @(posedge core_clk) begin
		if (!rst_b) core_divider_field <= POWER_MODE_RESET[CORE_DIVIDER_LSB +: 3];
		else if (power_commit) core_divider_field <= pwr_kif.commit_data[CORE_DIVIDER_LSB +: 3];
	end

	// Wake pulse for the rest of the chip
	always_ff @(posedge core_clk) begin
		if (!rst_b) wake_event <= 1'b0;
		else wake_event <= wake;
	end

	// ****************************************************************
	// Peripheral clock control
	// ****************************************************************
	// Serial source choice, keyed by the power keys
	always_ff @(posedge core_clk) begin
		if (!rst_b) serial_source_clock <= PERIPHERAL_CLOCK_RESET[SERIAL_SOURCE_LSB +: 2];
		else if (periph_commit) serial_source_clock <= pwr_kif.commit_data[SERIAL_SOURCE_LSB +: 2];
	end

	// ****************************************************************
	// Core clock tick
	// ****************************************************************
	logic [CORE_DIV_CNT_W-1:0] div_cnt;
	logic [CORE_DIV_CNT_W-1:0] div_mask;

	// Mask of 2^code - 1 sets the tick period
	assign div_mask = CORE_DIV_CNT_W'((8'h01 << core_divider_field) - 8'h01);

	// Free count; ticks stop outside active mode so the core holds still
	always_ff @(posedge core_clk) begin
		if (!rst_b) div_cnt <= '0;
		else div_cnt <= div_cnt + CORE_DIV_CNT_W'(1);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) core_tick <= 1'b0;
		else core_tick <= ((div_cnt & div_mask) == div_mask) && (power_mode_field == 3'(CPMC_ACTIVE));
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	logic [7:0] clock_system_view;
	logic [7:0] power_mode_view;
	logic [7:0] periph_view;

	// Reserved bits read as zero
	always_comb begin
		clock_system_view = 8'h00;
		clock_system_view[LOW_FREQ_SOURCE_BIT] = low_freq_source_select;
		clock_system_view[CLOCKING_MODE_LSB +: 2] = clocking_mode_field;
		power_mode_view = 8'h00;
		power_mode_view[POWER_MODE_LSB +: 3] = power_mode_field;
		power_mode_view[CORE_DIVIDER_LSB +: 3] = core_divider_field;
		periph_view = 8'h00;
		periph_view[SERIAL_SOURCE_LSB +: 2] = serial_source_clock;
	end

	// Data only in the cycle after a read; keys are write-only
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (hit_csc) reg_rdata <= {24'h000000, clock_system_view};
			else if (hit_pmc) reg_rdata <= {24'h000000, power_mode_view};
			else if (hit_pcc) reg_rdata <= {24'h000000, periph_view};
			else reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	unkeyed_power_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!pwr_kif.commit && !wake) |=> $stable(power_mode_field) && $stable(core_divider_field))
		else $error("power control changed without keyed commit");
	unkeyed_clock_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		!clk_kif.commit |=> $stable(clocking_mode_field) && $stable(low_freq_source_select))
		else $error("clock control changed without keyed commit");
	full_sequence_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_wr && hit_ck1 && reg_wdata[7:0] == CLOCK_KEY_FIRST_CODE) ##1
		(reg_wr && hit_csc && reg_wdata[1:0] == CLOCKING_MODE_EXTERNAL) ##1
		(reg_wr && hit_ck2 && reg_wdata[7:0] == CLOCK_KEY_SECOND_CODE)
		|-> ##2 clocking_mode_field == CLOCKING_MODE_EXTERNAL)
		else $error("keyed clock write not applied two cycles after second key");
	reserved_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		clocking_mode_field == CLOCKING_MODE_PLL || clocking_mode_field == CLOCKING_MODE_EXTERNAL)
		else $error("reserved clocking mode reached");
	reserved_power_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		power_mode_field <= 3'(CPMC_STOP))
		else $error("reserved power mode reached");
	wake_on_irq_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(asleep && external_interrupt_lines != 4'h0) |=> power_mode_field == 3'(CPMC_ACTIVE) && wake_event)
		else $error("sleep not left one cycle after interrupt");
	tick_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(power_mode_field != 3'(CPMC_ACTIVE)) |=> !core_tick)
		else $error("core tick outside active mode");
	tick_full_rate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(core_divider_field == 3'h0 && power_mode_field == 3'(CPMC_ACTIVE)) |=> core_tick)
		else $error("divider code zero did not tick every cycle");
	read_window_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_rd && hit_pcc) |=> reg_rdata == {24'h000000, $past(periph_view)})
		else $error("peripheral clock control read back wrong");

	// ****************************************************************
	// Checks on register effects and the read port
	// ****************************************************************
	// Read data stand one cycle only, and the keys never leak back
	read_clock_view_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_rd && hit_csc) |=> reg_rdata == {24'h000000, $past(clock_system_view)})
		else $error("clock system control read back wrong");
	read_power_view_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_rd && hit_pmc) |=> reg_rdata == {24'h000000, $past(power_mode_view)})
		else $error("power mode control read back wrong");
	read_idle_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		!reg_rd |=> reg_rdata == '0)
		else $error("read data outside the read window");
	read_key_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_rd && (hit_ck1 || hit_ck2 || hit_pk1 || hit_pk2)) |=> reg_rdata == '0)
		else $error("key register read back nonzero");
	// A commit lands in full one cycle later; a reserved code keeps the old mode
	clock_ref_apply_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_kif.commit |=> low_freq_source_select == $past(clk_kif.commit_data[LOW_FREQ_SOURCE_BIT]))
		else $error("reference select not taken from commit");
	clock_mode_apply_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clk_kif.commit && mode_legal) |=> clocking_mode_field == $past(next_clk_mode))
		else $error("legal clocking mode not applied");
	clock_mode_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clk_kif.commit && !mode_legal) |=> $stable(clocking_mode_field))
		else $error("reserved clocking code changed the mode");
	power_mode_apply_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(power_commit && pmode_legal && !wake) |=> power_mode_field == $past(next_pmode))
		else $error("legal power mode not applied");
	power_mode_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(power_commit && !pmode_legal && !wake) |=> $stable(power_mode_field))
		else $error("reserved power code changed the mode");
	divider_apply_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		power_commit |=> core_divider_field == $past(pwr_kif.commit_data[CORE_DIVIDER_LSB +: 3]))
		else $error("core divider not taken from commit");
	periph_apply_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		periph_commit |=> serial_source_clock == $past(pwr_kif.commit_data[SERIAL_SOURCE_LSB +: 2]))
		else $error("serial source not taken from commit");
	periph_unkeyed_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		!periph_commit |=> $stable(serial_source_clock))
		else $error("serial source changed without keyed commit");
	clock_commit_once_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_kif.commit |=> !clk_kif.commit)
		else $error("clock commit longer than one cycle");
	power_commit_once_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		pwr_kif.commit |=> !pwr_kif.commit)
		else $error("power commit longer than one cycle");
	wake_pulse_once_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wake_event |=> !wake_event)
		else $error("wake pulse longer than one cycle");
	wake_awake_none_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		!asleep |=> !wake_event)
		else $error("wake pulse while not asleep");
	tick_period_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(core_tick && core_divider_field != 3'h0 && $stable(core_divider_field)) |=> !core_tick)
		else $error("divided core tick on two cycles in a row");
endmodule // cpmc_top

// >>> cpmc_pkg.sv
/*
 * Shared constants for the clock and power mode control block: the register
 * map, field positions, reset values, key codes and mode encodings.
 * Assumes a 32-bit address and data register port and one 41.78 MHz clock.
 */
// What this block does
// - Clock control changes only through 0xAA to the first clock key, the new value, then 0x55 to the second key.
// - Power mode control is guarded by two write-only power keys, so a stray write cannot change mode or divider.
// - Bit 5 of clock system control picks the low-frequency reference, 1 internal (reset) and 0 external crystal.
// - Bits 1 to 0 of clock system control pick the clocking mode, 01 default PLL and 11 external clock.
// - Bits 6 to 4 of power mode control pick active, pause, nap, sleep or stop; other codes are reserved.
// - In sleep or stop, any of external interrupt lines 0 to 3 brings the part back to active.
// - Bits 2 to 0 of power mode control set the core clock, code 0 full rate and each step halving it.
// - Clock system control sets the clock mode, power mode control the core rate and power-down mode.
// - Bits 7 to 6 of peripheral clock control pick the source clock of the serial interface bit rate.
package cpmc_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam logic [31:0] ADDR_POWER_KEY_FIRST = 32'hFFFF0404;
	localparam logic [31:0] ADDR_POWER_MODE_CONTROL = 32'hFFFF0408;
	localparam logic [31:0] ADDR_POWER_KEY_SECOND = 32'hFFFF040C;
	localparam logic [31:0] ADDR_CLOCK_KEY_FIRST = 32'hFFFF0410;
	localparam logic [31:0] ADDR_CLOCK_SYSTEM_CONTROL = 32'hFFFF0414;
	localparam logic [31:0] ADDR_CLOCK_KEY_SECOND = 32'hFFFF0418;
	localparam logic [31:0] ADDR_PERIPHERAL_CLOCK_CONTROL = 32'hFFFF0420;

	// ****************************************************************
	// Key codes and reset values
	// ****************************************************************
	localparam logic [7:0] CLOCK_KEY_FIRST_CODE = 8'hAA;
	localparam logic [7:0] CLOCK_KEY_SECOND_CODE = 8'h55;
	localparam logic [7:0] POWER_KEY_FIRST_CODE = 8'hAA;
	localparam logic [7:0] POWER_KEY_SECOND_CODE = 8'h55;
	localparam logic [7:0] CLOCK_SYSTEM_RESET = 8'h21;
	localparam logic [7:0] POWER_MODE_RESET = 8'h00;
	localparam logic [7:0] PERIPHERAL_CLOCK_RESET = 8'h00;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int LOW_FREQ_SOURCE_BIT = 5;
	localparam int CLOCKING_MODE_LSB = 0;
	localparam int POWER_MODE_LSB = 4;
	localparam int CORE_DIVIDER_LSB = 0;
	localparam int SERIAL_SOURCE_LSB = 6;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	localparam logic [1:0] CLOCKING_MODE_PLL = 2'h1;
	localparam logic [1:0] CLOCKING_MODE_EXTERNAL = 2'h3;
	localparam int CORE_FULL_RATE_KHZ = 41780;
	localparam int CORE_DIV_CNT_W = 7;
	typedef enum logic [2:0] {
		CPMC_ACTIVE = 3'h0,
		CPMC_PAUSE = 3'h1,
		CPMC_NAP = 3'h2,
		CPMC_SLEEP = 3'h3,
		CPMC_STOP = 3'h4
	} cpmc_pmode_t;
endpackage

// >>> cpmc_key_if.sv
/*
 * Carrier between the register front end and a key sequencer.
 * Assumes both sides run on the block clock.
 */
`timescale 1ns/1ns
interface cpmc_key_if;
	logic access;
	logic key1_wr;
	logic val_wr;
	logic key2_wr;
	logic val_sel;
	logic [7:0] wdata;
	logic commit;
	logic commit_sel;
	logic [7:0] commit_data;
	modport seq (input access, input key1_wr, input val_wr, input key2_wr, input val_sel, input wdata,
		output commit, output commit_sel, output commit_data);
	modport user (output access, output key1_wr, output val_wr, output key2_wr, output val_sel,
		output wdata, input commit, input commit_sel, input commit_data);
endinterface

// >>> cpmc_key_seq.sv
/*
 * Key sequencer: first key, staged value, second key, then one commit pulse.
 * Assumes the user side raises access for every bus strobe of any address.
 */
`timescale 1ns/1ns
module cpmc_key_seq #(
	parameter logic [7:0] FIRST_CODE = 8'hAA,
	parameter logic [7:0] SECOND_CODE = 8'h55
) (
	input wire logic core_clk,
	input wire logic rst_b,
	cpmc_key_if.seq kif
);
	import cpmc_pkg::*;

	typedef enum logic [2:0] {
		CPMC_IDLE = 3'b001,
		CPMC_ARMED = 3'b010,
		CPMC_STAGED = 3'b100
	} cpmc_key_state_t;

	cpmc_key_state_t state;
	logic key1_ok;
	logic key2_ok;

	// Key matches
	assign key1_ok = kif.key1_wr && (kif.wdata == FIRST_CODE);
	assign key2_ok = kif.key2_wr && (kif.wdata == SECOND_CODE);

	// Sequence walk; any foreign access falls back to idle
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state <= CPMC_IDLE;
		end else begin
			unique case (state)
				CPMC_IDLE: begin
					if (key1_ok) state <= CPMC_ARMED;
				end
				CPMC_ARMED: begin
					if (kif.val_wr) state <= CPMC_STAGED;
					else if (key1_ok) state <= CPMC_ARMED;
					else if (kif.access) state <= CPMC_IDLE;
				end
				CPMC_STAGED: begin
					if (key1_ok) state <= CPMC_ARMED;
					else if (kif.access) state <= CPMC_IDLE;
				end
			endcase
		end
	end

	// Staged value, held until the second key
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			kif.commit_data <= 8'h00;
			kif.commit_sel <= 1'b0;
		end else if (state == CPMC_ARMED && kif.val_wr) begin
			kif.commit_data <= kif.wdata;
			kif.commit_sel <= kif.val_sel;
		end
	end

	// Commit pulse one cycle after a correct second key
	always_ff @(posedge core_clk) begin
		if (!rst_b) kif.commit <= 1'b0;
		else kif.commit <= (state == CPMC_STAGED) && key2_ok;
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	commit_after_key_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		kif.commit |-> $past(state == CPMC_STAGED) && $past(key2_ok))
		else $error("commit without staged value and second key");
	foreign_abort_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(state == CPMC_ARMED && kif.access && !kif.val_wr && !key1_ok) |=> state == CPMC_IDLE ##1 !kif.commit)
		else $error("pending update survived a foreign access");
	bad_key_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(state == CPMC_STAGED && kif.key2_wr && !key2_ok) |=> !kif.commit && state == CPMC_IDLE)
		else $error("wrong second key still committed");
endmodule // cpmc_key_seq

// >>> cpmc_testbench.sv
/*
 * Self-checking bench for the clock and power mode control block.
 * Assumes cpmc_pkg, cpmc_key_if, cpmc_key_seq and cpmc_top are compiled first.
 */
`timescale 1ns/1ns
module testbench;
	import cpmc_pkg::*;
	// ****************************************************************
	// Signals and expected state
	// ****************************************************************
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [3:0] external_interrupt_lines = 4'h0;
	logic low_freq_source_select;
	logic [1:0] clocking_mode_field;
	logic [2:0] power_mode_field;
	logic [2:0] core_divider_field;
	logic [1:0] serial_source_clock;
	logic core_tick;
	logic wake_event;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rd_notes[$];
	logic rd_pend = 1'b0;
	logic mon_on = 1'b0;
	logic [7:0] m_cs = 8'h21;
	logic [7:0] m_pm = 8'h00;
	logic [1:0] m_ss = 2'h0;
	logic [7:0] v;

	cpmc_top DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.external_interrupt_lines(external_interrupt_lines), .low_freq_source_select(low_freq_source_select),
		.clocking_mode_field(clocking_mode_field), .power_mode_field(power_mode_field),
		.core_divider_field(core_divider_field), .serial_source_clock(serial_source_clock),
		.core_tick(core_tick), .wake_event(wake_event));

	// ****************************************************************
	// Clock, hang guard and verdict
	// ****************************************************************
	always #5 core_clk = ~core_clk;

	// Generous ceiling; the longest stretch is the slowest divider
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 50000) begin
			err_total = err_total + 1;
			complete_run();
		end
	end

	task automatic complete_run();
		if (err_total == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ****************************************************************
	// Compare tasks
	// ****************************************************************
	task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value reg_rdata expected %h seen %h", exp, got);
		end
	endtask

	task automatic chk_port(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Read data stand only in the cycle after the strobe, zero otherwise
	always @(posedge core_clk) begin
		if (mon_on) begin
			if (rd_pend) begin
				chk_rd(rd_notes.pop_front(), reg_rdata);
			end else begin
				chk_rd(32'h0, reg_rdata);
			end
		end
		rd_pend <= reg_rd;
	end

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= {24'h0, d};
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// The note goes in before the strobe so the monitor always finds it
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		rd_notes.push_back(exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	// Second key sits eight bytes above the first; the three writes go back to back
	task automatic keyed(input logic [31:0] k1, input logic [31:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= k1;
		reg_wdata <= 32'h000000AA;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= {24'h0, d};
		@(posedge core_clk);
		reg_addr <= k1 + 32'h8;
		reg_wdata <= 32'h00000055;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// Reserved clocking codes have bit 0 clear and leave the mode alone
	task automatic set_cs(input logic [7:0] d);
		keyed(ADDR_CLOCK_KEY_FIRST, ADDR_CLOCK_SYSTEM_CONTROL, d);
		m_cs[5] = d[5];
		if (d[0]) m_cs[1:0] = d[1:0];
		settle();
	endtask

	task automatic set_pm(input logic [7:0] d);
		keyed(ADDR_POWER_KEY_FIRST, ADDR_POWER_MODE_CONTROL, d);
		m_pm[2:0] = d[2:0];
		if (d[6:4] <= 3'h4) m_pm[6:4] = d[6:4];
		settle();
	endtask

	task automatic check_all();
		chk_port("low_freq_source_select", 32'(m_cs[5]), 32'(low_freq_source_select));
		chk_port("clocking_mode_field", 32'(m_cs[1:0]), 32'(clocking_mode_field));
		chk_port("power_mode_field", 32'(m_pm[6:4]), 32'(power_mode_field));
		chk_port("core_divider_field", 32'(m_pm[2:0]), 32'(core_divider_field));
		chk_port("serial_source_clock", 32'(m_ss), 32'(serial_source_clock));
		rd(ADDR_CLOCK_SYSTEM_CONTROL, {24'h0, m_cs});
		rd(ADDR_POWER_MODE_CONTROL, {24'h0, m_pm});
		rd(ADDR_PERIPHERAL_CLOCK_CONTROL, {24'h0, m_ss, 6'h0});
	endtask

	// Eight periods after a quiet spell hold exactly eight ticks when active
	task automatic count_ticks();
		int n;
		int exp_n;
		n = 0;
		exp_n = (m_pm[6:4] == 3'h0) ? 8 : 0;
		repeat (128) @(posedge core_clk);
		repeat (8 << m_pm[2:0]) begin
			@(posedge core_clk);
			if (core_tick === 1'b1) n++;
		end
		chk_port("core_tick count", 32'(exp_n), 32'(n));
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'hA706));
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		mon_on <= 1'b1;
		check_all();
		// Keys and unmapped places read zero, stray writes do nothing
		rd(ADDR_CLOCK_KEY_FIRST, 32'h0);
		rd(ADDR_POWER_KEY_SECOND, 32'h0);
		rd(32'hFFFF041C, 32'h0);
		wr(32'hFFFF041C, 8'hFF);
		wr(ADDR_CLOCK_SYSTEM_CONTROL, 8'h03);
		wr(ADDR_POWER_MODE_CONTROL, 8'h17);
		settle();
		check_all();
		// Every clocking code, twice, with a random reference bit
		for (int i = 0; i < 8; i++) begin
			v = {2'h0, 1'($urandom_range(1)), 3'h0, 2'(i)};
			set_cs(v);
			check_all();
		end
		// Wrong second key, or any access between the keys, drops the update
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CLOCK_KEY_FIRST, 8'hAA);
			if (k == 3) rd(ADDR_POWER_MODE_CONTROL, {24'h0, m_pm});
			wr(ADDR_CLOCK_SYSTEM_CONTROL, m_cs ^ 8'h22);
			if (k == 1) rd(ADDR_CLOCK_SYSTEM_CONTROL, {24'h0, m_cs});
			if (k == 2) wr(ADDR_POWER_KEY_FIRST, 8'hAA);
			wr(ADDR_CLOCK_KEY_SECOND, (k == 0) ? 8'h54 : 8'h55);
			settle();
			check_all();
		end
		// All dividers while active, then every mode code with a random divider
		for (int i = 0; i < 16; i++) begin
			v = {1'b0, (i < 8) ? 3'h0 : 3'(i - 8), 1'b0, (i < 8) ? 3'(i) : 3'($urandom_range(7))};
			set_pm(v);
			check_all();
			count_ticks();
		end
		// All serial source codes through the power keys
		for (int i = 0; i < 4; i++) begin
			v = {2'(i), 6'($urandom_range(63))};
			keyed(ADDR_POWER_KEY_FIRST, ADDR_PERIPHERAL_CLOCK_CONTROL, v);
			m_ss = v[7:6];
			settle();
			check_all();
		end
		// Each line wakes sleep and stop; pause ignores the lines
		for (int i = 0; i < 12; i++) begin
			set_pm({1'b0, (i < 4) ? 3'h3 : (i < 8) ? 3'h4 : 3'h1, 4'h0});
			@(posedge core_clk);
			external_interrupt_lines <= 4'h1 << (i % 4);
			@(posedge core_clk);
			external_interrupt_lines <= 4'h0;
			#1;
			if (i < 8) m_pm[6:4] = 3'h0;
			chk_port("wake_event", 32'(i < 8), 32'(wake_event));
			chk_port("power_mode_field", 32'(m_pm[6:4]), 32'(power_mode_field));
			@(posedge core_clk);
			#1;
			chk_port("wake_event", 32'h0, 32'(wake_event));
			check_all();
		end
		repeat (3) @(posedge core_clk);
		complete_run();
	end
endmodule // testbench
